// ==== hw/rcc_top.sv ====
// Purpose: Reset cause record and run-mode clock configuration
// Assumes: Reset sources held with sys_rst; APB slave, zero wait states
// Notes:   Cause register lives outside sys_rst so it survives resets
`timescale 1ns/10ps
module rcc_top
   import rcc_pkg::*;
#(
   parameter int GATE_W = RCC_GATE_W
) (
   // Clock, reset, enable
   input  wire logic                clock,
   input  wire logic                sys_rst,
   input  wire logic                clk_en,
   // Reset source pulses, each with the reset it causes
   input  wire rcc_pkg::rcc_cause_s reset_src,
   // APB
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Power mode and gating registers
   input  wire rcc_pkg::rcc_mode_e  power_mode,
   input  wire logic [GATE_W-1:0]   run_gating_regs,
   input  wire logic [GATE_W-1:0]   sleep_gating_regs,
   input  wire logic [GATE_W-1:0]   deep_sleep_gating_regs,
   // Clock controls out
   output logic [GATE_W-1:0]        periph_clk_gate,
   output logic                     sys_clk_tick,
   output logic                     sys_use_divider,
   output logic                     sys_use_osc,
   output logic                     pwm_clk_tick
);
   import rcc_pkg::*;

   rcc_cause_s  cause_reg;
   rcc_config_s cfg_reg;
   logic [3:0]  divisor_read;
   logic        pll_in_use;
   logic        wr_cause;
   logic        wr_cfg;
   logic        access;
   logic        any_src;
   logic [6:0]  pwm_ratio;
   logic [4:0]  sys_ratio;

   function automatic logic [31:0] cause_word(input rcc_cause_s c);
      cause_word = {26'h0, c};
   endfunction : cause_word

   assign access   = psel && penable;
   assign wr_cause = access && pwrite && paddr == RCC_OFF_CAUSE;
   assign wr_cfg   = access && pwrite && paddr == RCC_OFF_CONFIG;
   assign any_src  = |reset_src;
   assign pready   = 1'b1;

   // Cause bits: not cleared by sys_rst so causes persist
   always_ff @(posedge clock)
   begin
      if (clk_en)
      begin
         if (reset_src.external_pin)
         begin
            cause_reg              <= '0;
            cause_reg.external_pin <= 1'b1;
         end
         else if (any_src)
         begin
            cause_reg <= cause_reg | reset_src;
         end
         else if (wr_cause)
            cause_reg <= rcc_cause_s'(pwdata[RCC_CAUSE_W-1:0]);
      end
   end

   // Configuration register
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         cfg_reg.auto_gating_select    <= 1'b0;
         cfg_reg.system_divisor        <= RCC_DIVISOR_RST;
         cfg_reg.system_divider_enable <= 1'b0;
         cfg_reg.pwm_divider_enable    <= 1'b0;
         cfg_reg.pwm_divisor           <= RCC_PWM_DIV_RST;
         cfg_reg.bypass                <= RCC_BYPASS_RST;
      end
      else if (clk_en && wr_cfg)
      begin
         cfg_reg.auto_gating_select    <= pwdata[RCC_BIT_AUTOGATE];
         cfg_reg.system_divisor        <= pwdata[RCC_DIVISOR_LSB +: 4];
         cfg_reg.system_divider_enable <= pwdata[RCC_BIT_USESYS];
         cfg_reg.pwm_divider_enable    <= pwdata[RCC_BIT_USEPWM];
         cfg_reg.pwm_divisor           <= pwdata[RCC_PWM_DIV_LSB +: 3];
         cfg_reg.bypass                <= pwdata[RCC_BIT_BYPASS];
      end
   end

   assign pll_in_use = !cfg_reg.bypass;

   // Clamp divisor while on PLL
   always_comb
   begin
      if (pll_in_use && cfg_reg.system_divisor < RCC_DIVISOR_MIN)
         divisor_read = RCC_DIVISOR_MIN;
      else
         divisor_read = cfg_reg.system_divisor;
   end

   // Read data register
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         prdata <= 32'h0;
      else if (clk_en && psel && !penable && !pwrite)
      begin
         if (paddr == RCC_OFF_CAUSE)
            prdata <= cause_word(cause_reg);
         else if (paddr == RCC_OFF_CONFIG)
         begin
            prdata                          <= 32'h0;
            prdata[RCC_BIT_AUTOGATE]        <= cfg_reg.auto_gating_select;
            prdata[RCC_DIVISOR_LSB +: 4]    <= divisor_read;
            prdata[RCC_BIT_USESYS]          <= cfg_reg.system_divider_enable;
            prdata[RCC_BIT_USEPWM]          <= cfg_reg.pwm_divider_enable;
            prdata[RCC_PWM_DIV_LSB +: 3]    <= cfg_reg.pwm_divisor;
            prdata[RCC_BIT_BYPASS]          <= cfg_reg.bypass;
         end
         else
            prdata <= 32'h0;
      end
   end

   assign pslverr = access && paddr != RCC_OFF_CAUSE
                    && paddr != RCC_OFF_CONFIG;

   // Peripheral gating selection
   always_comb
   begin
      periph_clk_gate = run_gating_regs;
      if (cfg_reg.auto_gating_select)
      begin
         unique case (power_mode)
            RCC_RUN:   periph_clk_gate = run_gating_regs;
            RCC_SLEEP: periph_clk_gate = sleep_gating_regs;
            RCC_DEEP:  periph_clk_gate = deep_sleep_gating_regs;
            default:   periph_clk_gate = run_gating_regs;
         endcase
      end
   end

   // Divider forced on PLL source
   assign sys_use_osc     = cfg_reg.bypass;
   assign sys_use_divider = cfg_reg.system_divider_enable
                            || pll_in_use;
   assign sys_ratio       = {1'b0, divisor_read} + 5'h1;

   // PWM ratio 2 << code, saturating at /64
   always_comb
   begin
      if (cfg_reg.pwm_divisor > RCC_PWM_DIV_MAX)
         pwm_ratio = 7'h40;
      else
         pwm_ratio = 7'(7'h2 << cfg_reg.pwm_divisor);
   end

   logic sys_tick_raw;
   logic pwm_tick_raw;

   rcc_clkdiv #(.W(5)) u_sys_div (
      .clock   (clock),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .div     (sys_ratio),
      .tick    (sys_tick_raw)
   );

   rcc_clkdiv #(.W(7)) u_pwm_div (
      .clock   (clock),
      .sys_rst (sys_rst),
      .clk_en  (clk_en && sys_clk_tick),
      .div     (pwm_ratio),
      .tick    (pwm_tick_raw)
   );

   assign sys_clk_tick = sys_use_divider ? sys_tick_raw : clk_en;
   assign pwm_clk_tick = cfg_reg.pwm_divider_enable ? pwm_tick_raw
                         : sys_clk_tick;
endmodule : rcc_top

// ==== include/rcc_pkg.sv ====
// Purpose: Constants and types for the reset cause and clock config block
// Assumes: APB slave, 32-bit data, byte addresses as printed
// Notes:   Contract
// Contract
// - External pin reset sets external bit and clears all other causes.
// - Other reset causes keep earlier cause bits; bits accumulate.
// - Power-good loss sets cause bit 5.
// - Software reset request sets cause bit 4.
// - Watchdog reset sets cause bit 3.
// - Brown-out reset sets cause bit 2.
// - Power-on reset sets cause bit 1.
// - External pin reset sets cause bit 0.
// - Auto gating bit 27 set: sleep and deep-sleep use their own gating.
// - Auto gating clear: run gating stays applied in sleep modes.
// - Run mode always uses run gating.
// - System divisor bits 26:23, reset 0xf, divides by value plus one.
// - PLL in use: divisor reads return the minimum if lower was written.
// - System divider enable at bit 22, reset 0, selects divided clock.
// - PLL source forces the system divider regardless of enable.
// - PWM divider enable at bit 20, reset 0, selects divided PWM clock.
// - Bypass bit 11, reset 1, selects oscillator; clear uses divided PLL.
// - PWM divisor bits 19:17, reset 0x7, power-of-two /2 to /64.
package rcc_pkg;
   localparam logic [11:0] RCC_OFF_CAUSE     = 12'h05c;
   localparam logic [11:0] RCC_OFF_CONFIG    = 12'h060;
   localparam int          RCC_CAUSE_W       = 6;
   localparam int          RCC_BIT_LDO       = 5;
   localparam int          RCC_BIT_SW        = 4;
   localparam int          RCC_BIT_WDT       = 3;
   localparam int          RCC_BIT_BOR       = 2;
   localparam int          RCC_BIT_POR       = 1;
   localparam int          RCC_BIT_EXT       = 0;
   localparam int          RCC_BIT_AUTOGATE  = 27;
   localparam int          RCC_DIVISOR_LSB   = 23;
   localparam int          RCC_BIT_USESYS    = 22;
   localparam int          RCC_BIT_USEPWM    = 20;
   localparam int          RCC_PWM_DIV_LSB   = 17;
   localparam int          RCC_BIT_BYPASS    = 11;
   localparam logic [3:0]  RCC_DIVISOR_RST   = 4'hf;
   localparam logic [3:0]  RCC_DIVISOR_MIN   = 4'h3;
   localparam logic [2:0]  RCC_PWM_DIV_RST   = 3'h7;
   localparam logic [2:0]  RCC_PWM_DIV_MAX   = 3'h5;
   localparam logic        RCC_BYPASS_RST    = 1'b1;
   localparam int          RCC_GATE_W        = 32;

   typedef enum logic [1:0] {RCC_RUN, RCC_SLEEP, RCC_DEEP} rcc_mode_e;

   typedef struct packed {
      logic power_good_lost;
      logic software;
      logic watchdog;
      logic brownout;
      logic power_on;
      logic external_pin;
   } rcc_cause_s;

   typedef struct packed {
      logic       auto_gating_select;
      logic [3:0] system_divisor;
      logic       system_divider_enable;
      logic       pwm_divider_enable;
      logic [2:0] pwm_divisor;
      logic       bypass;
   } rcc_config_s;
endpackage : rcc_pkg

// ==== hw/rcc_clkdiv.sv ====
// Purpose: Counter divider producing a one-cycle tick every div cycles
// Assumes: div of one or more; zero treated as one
// Notes:   Tick rises in phase with the source clock
`timescale 1ns/10ps
module rcc_clkdiv #(
   parameter int W = 7
) (
   // Clock and control
   input  wire logic         clock,
   input  wire logic         sys_rst,
   input  wire logic         clk_en,
   // Divide ratio
   input  wire logic [W-1:0] div,
   // Tick out
   output logic              tick
);
   logic [W-1:0] count_reg;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         count_reg <= '0;
      else if (clk_en)
      begin
         if (count_reg + W'(1) >= div)
            count_reg <= '0;
         else
            count_reg <= count_reg + W'(1);
      end
   end

   assign tick = clk_en && (count_reg + W'(1) >= div);
endmodule : rcc_clkdiv

// ==== verif/rcc_asserts.sv ====
// Purpose: Port-level assertions for rcc_top
// Assumes: Config shadow tracks APB writes
// Notes:   Cause bits are judged by the bench
`timescale 1ns/10ps
module rcc_asserts
   import rcc_pkg::*;
#(
   parameter int GATE_W = RCC_GATE_W
) (
   // Clock and control
   input wire logic              clock,
   input wire logic              sys_rst,
   input wire logic              clk_en,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   // Gating and clock select
   input wire rcc_mode_e         power_mode,
   input wire logic [GATE_W-1:0] run_gating_regs,
   input wire logic [GATE_W-1:0] sleep_gating_regs,
   input wire logic [GATE_W-1:0] deep_sleep_gating_regs,
   input wire logic [GATE_W-1:0] periph_clk_gate,
   input wire logic              sys_use_divider,
   input wire logic              sys_use_osc
);
   logic [31:0] cfg_reg;
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         cfg_reg <= 32'h078e0800;
      else if (clk_en && psel && penable && pwrite
               && paddr == RCC_OFF_CONFIG)
         cfg_reg <= pwdata & 32'h0fde0800;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence rd_low_div;
      clk_en && psel && !penable && !pwrite && paddr == RCC_OFF_CONFIG
         && !cfg_reg[11] && cfg_reg[26:23] < 4'h3;
   endsequence
   a_clamp_read: assert property (
      rd_low_div |=> prdata[26:23] == RCC_DIVISOR_MIN)
      else $error("divisor read not clamped");
   a_run_gate: assert property (
      power_mode == RCC_RUN |-> periph_clk_gate == run_gating_regs)
      else $error("run gating not applied");
   a_sleep_plain: assert property (
      power_mode != RCC_RUN && !cfg_reg[27]
         |-> periph_clk_gate == run_gating_regs)
      else $error("run gating lost in sleep");
   a_auto_sleep: assert property (
      power_mode == RCC_SLEEP && cfg_reg[27]
         |-> periph_clk_gate == sleep_gating_regs)
      else $error("sleep gating not applied");
   a_auto_deep: assert property (
      power_mode == RCC_DEEP && cfg_reg[27]
         |-> periph_clk_gate == deep_sleep_gating_regs)
      else $error("deep sleep gating not applied");
   a_osc_select: assert property (
      sys_use_osc == cfg_reg[11])
      else $error("oscillator select wrong");
   a_pll_forces: assert property (
      !cfg_reg[11] |-> sys_use_divider)
      else $error("divider not forced");
   a_div_enable: assert property (
      cfg_reg[11] |-> sys_use_divider == cfg_reg[22])
      else $error("divider enable ignored");
endmodule : rcc_asserts
bind rcc_top rcc_asserts #(.GATE_W(GATE_W)) i_chk (
   .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .power_mode(power_mode),
   .run_gating_regs(run_gating_regs),
   .sleep_gating_regs(sleep_gating_regs),
   .deep_sleep_gating_regs(deep_sleep_gating_regs),
   .periph_clk_gate(periph_clk_gate),
   .sys_use_divider(sys_use_divider), .sys_use_osc(sys_use_osc));

// ==== verif/rcc_top_tb.sv ====
// Purpose: Self-checking bench for rcc_top
// Assumes: Zero wait APB slave, clk_en high except in the hold scenario
// Notes:   Gating inputs are fixed distinct patterns
`timescale 1ns/10ps
module rcc_top_tb;
   import rcc_pkg::*;
   logic        clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, gate;
   logic        pready, pslverr, err, st, pt, ud, uo;
   logic        ce = 1'b1;
   rcc_cause_s  reset_src = '0;
   rcc_mode_e   power_mode = RCC_RUN;
   int          n_mismatch = 0, cmp_count = 0;
   always #2.5 clock = ~clock;
   rcc_top i_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(ce),
      .reset_src(reset_src), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
      .run_gating_regs(32'h1111), .sleep_gating_regs(32'h2222),
      .deep_sleep_gating_regs(32'h3333), .periph_clk_gate(gate),
      .sys_clk_tick(st), .sys_use_divider(ud), .sys_use_osc(uo),
      .pwm_clk_tick(pt));
   task automatic results;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clock);
         if (pready === 1'b1)
            break;
      end
      if (k == 20)
      begin
         n_mismatch++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic pulse(rcc_cause_s s);
      @(posedge clock);
      reset_src <= s;
      sys_rst <= 1'b1;
      @(posedge clock);
      reset_src <= '0;
      sys_rst <= 1'b0;
   endtask : pulse
   task automatic t_reset;
      apb(0, RCC_OFF_CONFIG, 0);
      chk("config", 32'h078e0800, rd);
      chk("osc", 1, uo);
      chk("pready", 1, pready);
      apb(1, 12'h064, 32'hffffffff);
      chk("slverr", 1, err);
      apb(0, RCC_OFF_CONFIG, 0);
      chk("config", 32'h078e0800, rd);
   endtask : t_reset
   task automatic t_hold;
      @(posedge clock);
      ce <= 1'b0;
      apb(1, RCC_OFF_CONFIG, 0);
      ce <= 1'b1;
      apb(0, RCC_OFF_CONFIG, 0);
      chk("frozen config", 32'h078e0800, rd);
   endtask : t_hold
   task automatic t_cause;
      logic [31:0] m;
      apb(1, RCC_OFF_CAUSE, 0);
      apb(0, RCC_OFF_CAUSE, 0);
      chk("cause", 0, rd);
      m = 0;
      for (int i = 1; i < 6; i++)
      begin
         pulse(rcc_cause_s'(6'h01 << i));
         m[i] = 1'b1;
         apb(0, RCC_OFF_CAUSE, 0);
         chk("cause", m, rd);
      end
      pulse(rcc_cause_s'(6'h21));
      apb(0, RCC_OFF_CAUSE, 0);
      chk("cause", 1, rd);
      apb(1, RCC_OFF_CAUSE, 32'h2a);
      apb(0, RCC_OFF_CAUSE, 0);
      chk("cause", 32'h2a, rd);
   endtask : t_cause
   task automatic t_clamp;
      apb(1, RCC_OFF_CONFIG, 32'h00800000);
      apb(0, RCC_OFF_CONFIG, 0);
      chk("divisor", 4'h3, rd[26:23]);
      chk("usediv", 1, ud);
      apb(1, RCC_OFF_CONFIG, 32'h00800800);
      apb(0, RCC_OFF_CONFIG, 0);
      chk("divisor", 4'h1, rd[26:23]);
   endtask : t_clamp
   task automatic t_gate;
      for (int a = 0; a < 2; a++)
      begin
         apb(1, RCC_OFF_CONFIG, (32'(a) << 27) | 32'h800);
         for (int m = 0; m < 3; m++)
         begin
            @(posedge clock);
            power_mode <= rcc_mode_e'(m);
            @(posedge clock);
            chk("gate", (a && m) ? 32'h1111 * (m + 1) : 32'h1111, gate);
         end
      end
      @(posedge clock);
      power_mode <= RCC_RUN;
   endtask : t_gate
   task automatic ticks(logic [31:0] c, int n, int es, int ep);
      int ns, np;
      apb(1, RCC_OFF_CONFIG, c);
      repeat (150) @(posedge clock);
      ns = 0;
      np = 0;
      repeat (n)
      begin
         @(posedge clock);
         ns += (st === 1'b1);
         np += (pt === 1'b1);
      end
      chk("sys ticks", es, ns);
      chk("pwm ticks", ep, np);
   endtask : ticks
   initial
   begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset();
      t_hold();
      t_cause();
      t_clamp();
      t_gate();
      ticks(32'h01d00800, 40, 10, 5);
      ticks(32'h001c0800, 128, 128, 2);
      results();
   end
endmodule : rcc_top_tb
